// [rtl/ssp_pkg.sv]
package ssp_pkg;
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_CON1 = 8'h04;
  localparam logic [7:0] OFS_CON2 = 8'h08;
  localparam logic [7:0] OFS_BUF = 8'h0c;
  localparam logic [7:0] OFS_ISTAT = 8'h10;
  localparam logic [7:0] OFS_IMASK = 8'h14;
  localparam int STAT_EN = 15;
  localparam int STAT_SIDL = 13;
  localparam int STAT_ROV = 6;
  localparam int STAT_TBF = 1;
  localparam int STAT_RBF = 0;
  localparam int C1_CLK_DIS = 12;
  localparam int C1_DOUT_DIS = 11;
  localparam int C1_W16 = 10;
  localparam int C1_SMP = 9;
  localparam int C1_SELECT_PIN_ENABLE = 7;
  localparam int C1_CKP = 6;
  localparam int C1_MST = 5;
  localparam int C1_PPRE = 0;
  localparam int C2_FRM = 15;
  localparam int C2_FSD = 14;
  localparam int C2_FPOL = 13;
  localparam int C2_FDLY = 1;
  localparam logic [15:0] CON1_MASK = 16'h1fff;
  localparam logic [15:0] CON2_MASK = 16'he002;
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;
  localparam logic [15:0] BUF_RST = 16'h0000;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OV = 2;
  localparam logic [1:0] PRE_4 = 2'h2;
  localparam logic [1:0] PRE_16 = 2'h1;
  localparam logic [1:0] PRE_64 = 2'h0;
  localparam logic [5:0] HALF_4 = 6'h02;
  localparam logic [5:0] HALF_16 = 6'h08;
  localparam logic [5:0] HALF_64 = 6'h20;
  localparam logic [5:0] HALF_OTHER = 6'h01;
  localparam logic [4:0] BITS_WORD = 5'h10;
  localparam logic [4:0] BITS_BYTE = 5'h08;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_RUN} ssp_state_t;

  // half of one shift clock period, in system clocks
  function automatic logic [5:0] half_cnt(input logic [1:0] code);
    case (code)
      PRE_4: half_cnt = HALF_4;
      PRE_16: half_cnt = HALF_16;
      PRE_64: half_cnt = HALF_64;
      default: half_cnt = HALF_OTHER;
    endcase
  endfunction : half_cnt

  function automatic logic [4:0] word_bits(input logic w16);
    word_bits = w16 ? BITS_WORD : BITS_BYTE;
  endfunction : word_bits
endpackage : ssp_pkg

// [rtl/ssp_tick_if.sv]
`timescale 1ns/1ps
interface ssp_tick_if;
  logic run;
  logic [1:0] code;
  logic tick;
  modport ctl (output run, output code, input tick);
  modport gen (input run, input code, output tick);
endinterface : ssp_tick_if

// [rtl/ssp_prescaler.sv]
`timescale 1ns/1ps
module ssp_prescaler (
  input wire logic i_clk,
  input wire logic i_arst_n,
  ssp_tick_if.gen tk
);
  logic [5:0] cnt_ff;
  logic [5:0] last;

  assign last = ssp_pkg::half_cnt(tk.code) - 6'h01;
  assign tk.tick = tk.run && (cnt_ff == last);

  // restarts with every transfer so the first half period is full length
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 6'h00;
    end else if (!tk.run || cnt_ff == last) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end
endmodule : ssp_prescaler

// [rtl/ssp_top.sv]
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module ssp_top #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_cpu_idle,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_ssel_n,
  output logic o_ssel,
  output logic o_ssel_oe,
  output logic o_irq
);
  logic en_ff;
  logic sidl_ff;
  logic rov_ff;
  logic tbf_ff;
  logic rbf_ff;
  logic [15:0] con1_ff;
  logic [15:0] con2_ff;
  logic [15:0] txb_ff;
  logic [15:0] rxb_ff;
  logic [15:0] sr_ff;
  logic [15:0] rdata_ff;
  logic [2:0] isr_ff;
  logic [2:0] imask_ff;
  ssp_pkg::ssp_state_t state_ff;
  logic [4:0] cnt_ff;
  logic phase_ff;
  logic smp_ff;
  logic sck_q_ff;
  logic sck_ff;
  logic fs_on_ff;
  logic armed_ff;

  logic wr_stat, wr_con1, wr_con2, wr_buf, wr_istat, wr_imask;
  logic rd_buf;
  logic act, mst, w16, clock_polarity, frm, fsd, fpol, fdly;
  logic fs_in, sl_sel, s_edge, s_lead, s_trail;
  logic m_run, m_lead, m_trail, m_start, s_load, load;
  logic lead, trail, done, abort, bit_in;
  logic [4:0] nbits;
  logic [15:0] word_in, rx_word, ld_val;
  logic [2:0] ev;

  ssp_tick_if tk ();

  ssp_prescaler u_pre (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .tk(tk.gen)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  assign wr_stat = i_wr && hit(i_addr, ssp_pkg::OFS_STAT);
  assign wr_con1 = i_wr && hit(i_addr, ssp_pkg::OFS_CON1);
  assign wr_con2 = i_wr && hit(i_addr, ssp_pkg::OFS_CON2);
  assign wr_buf = i_wr && hit(i_addr, ssp_pkg::OFS_BUF);
  assign wr_istat = i_wr && hit(i_addr, ssp_pkg::OFS_ISTAT);
  assign wr_imask = i_wr && hit(i_addr, ssp_pkg::OFS_IMASK);
  assign rd_buf = i_rd && hit(i_addr, ssp_pkg::OFS_BUF);

  assign act = en_ff && !(sidl_ff && i_cpu_idle);
  assign mst = con1_ff[ssp_pkg::C1_MST];
  assign w16 = con1_ff[ssp_pkg::C1_W16];
  assign clock_polarity = con1_ff[ssp_pkg::C1_CKP];
  assign frm = con2_ff[ssp_pkg::C2_FRM];
  assign fsd = con2_ff[ssp_pkg::C2_FSD];
  assign fpol = con2_ff[ssp_pkg::C2_FPOL];
  assign fdly = con2_ff[ssp_pkg::C2_FDLY];

  // select pin doubles as frame sync input when framing
  assign fs_in = (i_ssel_n == fpol);
  assign sl_sel = frm ? (armed_ff || fs_in)
                      : (!con1_ff[ssp_pkg::C1_SELECT_PIN_ENABLE] || !i_ssel_n);
  // slave clock is sampled as a plain input, no second domain
  assign s_edge = i_sck ^ sck_q_ff;
  assign s_lead = s_edge && (i_sck != clock_polarity);
  assign s_trail = s_edge && (i_sck == clock_polarity);

  assign tk.run = act && mst && (state_ff != ssp_pkg::ST_IDLE);
  assign tk.code = con1_ff[ssp_pkg::C1_PPRE +: 2];
  assign m_run = mst && (state_ff != ssp_pkg::ST_IDLE);
  assign m_lead = m_run && tk.tick && !phase_ff;
  assign m_trail = m_run && tk.tick && phase_ff;
  assign m_start = act && mst && (state_ff == ssp_pkg::ST_IDLE) && tbf_ff &&
                   (!frm || !fsd || fs_in);
  // slave preloads as soon as a word waits, ready for the first edge
  assign s_load = act && !mst && (state_ff == ssp_pkg::ST_IDLE) && tbf_ff;
  assign load = m_start || s_load;

  assign lead = act && (mst ? (m_lead && state_ff == ssp_pkg::ST_RUN)
                            : (sl_sel && s_lead));
  assign trail = act && (state_ff == ssp_pkg::ST_RUN) &&
                 (mst ? m_trail : (sl_sel && s_trail));
  assign nbits = ssp_pkg::word_bits(w16);
  assign done = trail && ((cnt_ff + 5'h01) == nbits);
  assign abort = (state_ff != ssp_pkg::ST_IDLE) &&
                 (!act || (!mst && !sl_sel));

  // late sampling only makes sense when we own the clock
  assign bit_in = (mst && con1_ff[ssp_pkg::C1_SMP]) ? i_sdi : smp_ff;
  assign word_in = {sr_ff[14:0], bit_in};
  assign rx_word = w16 ? word_in : {8'h00, word_in[7:0]};
  // bytes ride in the top half so bit 15 is always the one on the pin
  assign ld_val = w16 ? txb_ff : {txb_ff[7:0], 8'h00};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ssp_pkg::ST_IDLE;
    end else if (abort) begin
      state_ff <= ssp_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        ssp_pkg::ST_IDLE: begin
          if (m_start) begin
            state_ff <= (frm && !fdly) ? ssp_pkg::ST_SYNC
                                       : ssp_pkg::ST_RUN;
          end else if (!mst && lead) begin
            state_ff <= ssp_pkg::ST_RUN;
          end
        end
        ssp_pkg::ST_SYNC: begin
          if (m_trail) begin
            state_ff <= ssp_pkg::ST_RUN;
          end
        end
        ssp_pkg::ST_RUN: begin
          if (done) begin
            state_ff <= ssp_pkg::ST_IDLE;
          end
        end
        default: state_ff <= ssp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= 5'h00;
    end else if (abort || state_ff == ssp_pkg::ST_IDLE) begin
      cnt_ff <= 5'h00;
    end else if (trail) begin
      cnt_ff <= done ? 5'h00 : cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_ff <= 1'b0;
    end else if (!m_run) begin
      phase_ff <= 1'b0;
    end else if (tk.tick) begin
      phase_ff <= !phase_ff;
    end
  end

  // clock stays idle through the sync slot
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_ff <= 1'b0;
    end else if (!mst || state_ff != ssp_pkg::ST_RUN) begin
      sck_ff <= clock_polarity;
    end else if (tk.tick) begin
      sck_ff <= phase_ff ? clock_polarity : !clock_polarity;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sr_ff <= ssp_pkg::BUF_RST;
    end else if (load) begin
      sr_ff <= ld_val;
    end else if (trail) begin
      sr_ff <= word_in;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      smp_ff <= 1'b0;
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= i_sck;
      if (lead) begin
        smp_ff <= i_sdi;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_ff <= 1'b0;
    end else if (!frm || mst || done || !act) begin
      armed_ff <= 1'b0;
    end else if (fs_in) begin
      armed_ff <= 1'b1;
    end
  end

  // pulse runs for the sync slot, or for the first bit when coincident
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fs_on_ff <= 1'b0;
    end else if (m_start) begin
      fs_on_ff <= frm;
    end else if (m_trail || !m_run) begin
      fs_on_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tbf_ff <= 1'b0;
    end else if (wr_buf) begin
      tbf_ff <= 1'b1;
    end else if (load) begin
      tbf_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txb_ff <= ssp_pkg::BUF_RST;
    end else if (wr_buf) begin
      txb_ff <= i_wdata;
    end
  end

  // a finished word never overwrites an unread one
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rbf_ff <= 1'b0;
      rxb_ff <= ssp_pkg::BUF_RST;
    end else if (done && !rbf_ff) begin
      rbf_ff <= 1'b1;
      rxb_ff <= rx_word;
    end else if (rd_buf) begin
      rbf_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rov_ff <= 1'b0;
    end else if (done && rbf_ff) begin
      rov_ff <= 1'b1;
    end else if (wr_stat && !i_wdata[ssp_pkg::STAT_ROV]) begin
      rov_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_ff <= 1'b0;
      sidl_ff <= 1'b0;
    end else if (wr_stat) begin
      en_ff <= i_wdata[ssp_pkg::STAT_EN];
      sidl_ff <= i_wdata[ssp_pkg::STAT_SIDL];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      con1_ff <= ssp_pkg::CON1_RST;
      con2_ff <= ssp_pkg::CON2_RST;
    end else begin
      if (wr_con1) begin
        con1_ff <= i_wdata & ssp_pkg::CON1_MASK;
      end
      if (wr_con2) begin
        con2_ff <= i_wdata & ssp_pkg::CON2_MASK;
      end
    end
  end

  assign ev[ssp_pkg::IRQ_RX] = done && !rbf_ff;
  assign ev[ssp_pkg::IRQ_TX] = load;
  assign ev[ssp_pkg::IRQ_OV] = done && rbf_ff;

  // new events win over a same-cycle write-one clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      isr_ff <= 3'h0;
    end else begin
      isr_ff <= (isr_ff & ~(wr_istat ? i_wdata[2:0] : 3'h0)) | ev;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      imask_ff <= ssp_pkg::IMASK_RST;
    end else if (wr_imask) begin
      imask_ff <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 16'h0000;
    end else if (!i_rd) begin
      rdata_ff <= 16'h0000;
    end else if (hit(i_addr, ssp_pkg::OFS_STAT)) begin
      rdata_ff <= 16'h0000;
      rdata_ff[ssp_pkg::STAT_EN] <= en_ff;
      rdata_ff[ssp_pkg::STAT_SIDL] <= sidl_ff;
      rdata_ff[ssp_pkg::STAT_ROV] <= rov_ff;
      rdata_ff[ssp_pkg::STAT_TBF] <= tbf_ff;
      rdata_ff[ssp_pkg::STAT_RBF] <= rbf_ff;
    end else if (hit(i_addr, ssp_pkg::OFS_CON1)) begin
      rdata_ff <= con1_ff;
    end else if (hit(i_addr, ssp_pkg::OFS_CON2)) begin
      rdata_ff <= con2_ff;
    end else if (rd_buf) begin
      rdata_ff <= rxb_ff;
    end else if (hit(i_addr, ssp_pkg::OFS_ISTAT)) begin
      rdata_ff <= {13'h0000, isr_ff};
    end else if (hit(i_addr, ssp_pkg::OFS_IMASK)) begin
      rdata_ff <= {13'h0000, imask_ff};
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_sdo = sr_ff[15];
  assign o_sdo_oe = act && !con1_ff[ssp_pkg::C1_DOUT_DIS] &&
                    (mst || sl_sel);
  assign o_sck = sck_ff;
  assign o_sck_oe = act && mst && !con1_ff[ssp_pkg::C1_CLK_DIS];
  assign o_ssel = fs_on_ff ? fpol : !fpol;
  assign o_ssel_oe = act && mst && frm && !fsd;
  assign o_irq = |(isr_ff & imask_ff);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_bit_half4;
    m_lead ##2 m_trail;
  endsequence

  sequence s_bit_half64;
    m_lead ##32 m_trail;
  endsequence

  chk_tbf_set: assert property (
    wr_buf |=> tbf_ff && txb_ff == $past(i_wdata))
    else $error("tx full not set by buffer write");

  chk_tbf_clear: assert property (
    load && !wr_buf |=> !tbf_ff && sr_ff == $past(ld_val))
    else $error("tx full not cleared on load");

  chk_rbf_set: assert property (
    done && !rbf_ff |=> rbf_ff && rxb_ff == $past(rx_word))
    else $error("rx word not captured");

  chk_rbf_clear: assert property (
    rd_buf && !done |=> !rbf_ff)
    else $error("rx full not cleared by read");

  chk_rov_drop: assert property (
    done && rbf_ff && !rd_buf |=> rov_ff && $stable(rxb_ff) && rbf_ff)
    else $error("overflow word not dropped");

  chk_word_count: assert property (
    done |-> cnt_ff == (w16 ? 5'h0f : 5'h07))
    else $error("wrong bit count per word");

  chk_pre_div4: assert property (
    m_lead && state_ff == ssp_pkg::ST_RUN && tk.code == ssp_pkg::PRE_4
      && act && !wr_con1 |-> s_bit_half4)
    else $error("divide by 4 half period wrong");

  chk_pre_div64: assert property (
    m_lead && state_ff == ssp_pkg::ST_RUN && tk.code == ssp_pkg::PRE_64
      && act && !wr_con1 ##1 (act && !wr_con1)[*8] |-> ##24 m_trail)
    else $error("divide by 64 half period wrong");

  chk_mst_clk: assert property (
    act && mst && !con1_ff[ssp_pkg::C1_CLK_DIS] |-> o_sck_oe && o_sck == sck_ff)
    else $error("master not driving clock");

  chk_sdo_off: assert property (
    con1_ff[ssp_pkg::C1_DOUT_DIS] |-> !o_sdo_oe)
    else $error("data out driven while disabled");

  chk_frame_edge: assert property (
    m_start && frm |=> fs_on_ff &&
      (state_ff == (fdly ? ssp_pkg::ST_RUN : ssp_pkg::ST_SYNC)))
    else $error("frame pulse placement wrong");
endmodule : ssp_top

// [tb/ssp_peer.sv]
`timescale 1ns/1ps
module ssp_peer (
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_w16,
  input wire logic i_load,
  input wire logic [15:0] i_tx,
  output logic o_sdi,
  output logic [15:0] o_rx
);
  logic [15:0] sh_ff = 16'h0000;
  initial o_rx = 16'h0000;
  always @(posedge i_load) sh_ff = i_tx;
  // idle-low clock: take data on the rise, change on the fall
  always @(posedge i_sck) o_rx = {o_rx[14:0], i_sdo};
  // inverse shifted in, so a line past its word never repeats a bit
  always @(negedge i_sck) sh_ff = {sh_ff[14:0], ~sh_ff[15]};
  assign o_sdi = i_w16 ? sh_ff[15] : sh_ff[7];
endmodule : ssp_peer

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic i_clk;
  logic i_arst_n;
  logic [7:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [15:0] o_rdata;
  logic sdi_w, o_sdo, o_sdo_oe, o_sck, o_sck_oe, o_ssel, o_ssel_oe, o_irq;
  logic pk_load, pk_w16;
  logic [15:0] pk_tx, pk_rx, rv;
  logic sck_tb, peer_sck;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int la, pa, lb, pb;
  int per_tab[4] = '{64, 16, 4, 2};

  ssp_top ssp_top_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cpu_idle(1'b0), .i_sdi(sdi_w), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .i_sck(sck_tb), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .i_ssel_n(1'b1), .o_ssel(o_ssel),
    .o_ssel_oe(o_ssel_oe), .o_irq(o_irq));

  // peer follows whoever owns the clock
  assign peer_sck = o_sck_oe ? o_sck : sck_tb;

  ssp_peer ssp_peer_inst (.i_sck(peer_sck), .i_sdo(o_sdo), .i_w16(pk_w16),
    .i_load(pk_load), .i_tx(pk_tx), .o_sdi(sdi_w), .o_rx(pk_rx));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // longest path is four byte transfers, one at each divide from the slowest
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // gap cycle after each write keeps one assignment per strobe per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_clk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask : rd_chk

  task automatic poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    rd(a, rv);
    while (rv[b] !== 1'b1 && k < 400) begin
      rd(a, rv);
      k++;
    end
    chk({15'h0000, rv[b]}, 16'h0001);
  endtask : poll

  task automatic pins_chk(input logic [3:0] exp);
    repeat (3) @(negedge i_clk);
    chk({12'h000, o_sdo_oe, o_sck_oe, o_ssel_oe, o_irq}, {12'h000, exp});
    @(posedge i_clk);
  endtask : pins_chk

  task automatic wait_sck(input logic lv, inout int n);
    while (o_sck !== lv && n < 3000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : wait_sck

  task automatic run_word(input logic [15:0] c1, input logic [15:0] mine,
      input logic [15:0] theirs, output int lead, output int per);
    logic [15:0] m;
    int n;
    m = c1[ssp_pkg::C1_W16] ? 16'hffff : 16'h00ff;
    pk_w16 <= c1[ssp_pkg::C1_W16];
    pk_tx <= theirs;
    pk_load <= 1'b1;
    wr(ssp_pkg::OFS_CON1, c1);
    pk_load <= 1'b0;
    wr(ssp_pkg::OFS_STAT, 16'h8000);
    i_wr <= 1'b1;
    i_addr <= ssp_pkg::OFS_BUF;
    i_wdata <= mine;
    @(posedge i_clk);
    i_wr <= 1'b0;
    rd_chk(ssp_pkg::OFS_STAT, 16'h8002);
    n = 0;
    #1;
    wait_sck(1'b1, n);
    lead = n;
    wait_sck(1'b0, n);
    wait_sck(1'b1, n);
    per = n - lead;
    @(posedge i_clk);
    poll(ssp_pkg::OFS_ISTAT, ssp_pkg::IRQ_RX);
    rd_chk(ssp_pkg::OFS_STAT, 16'h8001);
    rd_chk(ssp_pkg::OFS_BUF, theirs & m);
    chk(pk_rx & m, mine & m);
    rd_chk(ssp_pkg::OFS_STAT, 16'h8000);
    wr(ssp_pkg::OFS_ISTAT, 16'h0007);
  endtask : run_word

  task automatic t_reset;
    pins_chk(4'b0000);
    rd_chk(ssp_pkg::OFS_STAT, 16'h0000);
    rd_chk(ssp_pkg::OFS_CON1, ssp_pkg::CON1_RST);
    rd_chk(ssp_pkg::OFS_CON2, ssp_pkg::CON2_RST);
    rd_chk(ssp_pkg::OFS_BUF, ssp_pkg::BUF_RST);
    rd_chk(ssp_pkg::OFS_IMASK, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    wr(ssp_pkg::OFS_CON1, 16'hffff);
    rd_chk(ssp_pkg::OFS_CON1, ssp_pkg::CON1_MASK);
    // edge bit cleared before framing goes on, bit 0 never written high
    wr(ssp_pkg::OFS_CON1, 16'h0000);
    wr(ssp_pkg::OFS_CON2, 16'hfffe);
    rd_chk(ssp_pkg::OFS_CON2, ssp_pkg::CON2_MASK);
    wr(ssp_pkg::OFS_CON2, 16'h0000);
  endtask : t_reset

  task automatic t_pins;
    wr(ssp_pkg::OFS_CON1, 16'h0022);
    wr(ssp_pkg::OFS_STAT, 16'h8000);
    pins_chk(4'b1100);
    wr(ssp_pkg::OFS_CON1, 16'h0822);
    pins_chk(4'b0100);
    wr(ssp_pkg::OFS_CON1, 16'h1022);
    pins_chk(4'b1000);
    wr(ssp_pkg::OFS_CON1, 16'h0002);
    pins_chk(4'b1000);
    wr(ssp_pkg::OFS_STAT, 16'h0000);
  endtask : t_pins

  task automatic t_speed;
    for (int k = 0; k < 4; k++) begin
      run_word(16'h0020 | 16'(k), 16'h00a5 ^ 16'(k), 16'h003c, la, pa);
      chk(16'(pa), 16'(per_tab[k]));
    end
    run_word(16'h0422, 16'hc3a5, 16'h5e71, la, pa);
    // late sampling: master takes data in at the trailing edge
    run_word(16'h0222, 16'h0069, 16'h00b4, la, pa);
  endtask : t_speed

  task automatic t_over;
    wr(ssp_pkg::OFS_IMASK, 16'h0004);
    pk_w16 <= 1'b0;
    pk_tx <= 16'h0096;
    pk_load <= 1'b1;
    wr(ssp_pkg::OFS_CON1, 16'h0022);
    pk_load <= 1'b0;
    wr(ssp_pkg::OFS_STAT, 16'h8000);
    wr(ssp_pkg::OFS_BUF, 16'h005a);
    poll(ssp_pkg::OFS_ISTAT, ssp_pkg::IRQ_RX);
    pins_chk(4'b1100);
    wr(ssp_pkg::OFS_BUF, 16'h00c3);
    poll(ssp_pkg::OFS_ISTAT, ssp_pkg::IRQ_OV);
    pins_chk(4'b1101);
    rd_chk(ssp_pkg::OFS_STAT, 16'h8041);
    rd_chk(ssp_pkg::OFS_BUF, 16'h0096);
    wr(ssp_pkg::OFS_STAT, 16'h8000);
    rd_chk(ssp_pkg::OFS_STAT, 16'h8000);
    wr(ssp_pkg::OFS_ISTAT, 16'h0007);
    pins_chk(4'b1100);
    wr(ssp_pkg::OFS_IMASK, 16'h0000);
  endtask : t_over

  // clock edge bit stays zero in every framed setup
  task automatic t_frame;
    wr(ssp_pkg::OFS_CON2, 16'h8002);
    run_word(16'h0022, 16'h0081, 16'h0042, lb, pb);
    wr(ssp_pkg::OFS_CON2, 16'h8000);
    run_word(16'h0022, 16'h0018, 16'h0024, la, pa);
    chk(16'(la - lb), 16'(pa));
    pins_chk(4'b1110);
    #1;
    // active-low sync pulse sits inactive between frames
    chk({15'h0000, o_ssel}, 16'h0001);
    wr(ssp_pkg::OFS_CON2, 16'h0000);
    wr(ssp_pkg::OFS_STAT, 16'h0000);
  endtask : t_frame

  // far party owns the clock; half period long against the edge delay
  task automatic t_slave;
    pk_w16 <= 1'b0;
    pk_tx <= 16'h00d2;
    pk_load <= 1'b1;
    wr(ssp_pkg::OFS_CON1, 16'h0000);
    pk_load <= 1'b0;
    wr(ssp_pkg::OFS_STAT, 16'h8000);
    wr(ssp_pkg::OFS_BUF, 16'h004b);
    repeat (8) begin
      sck_tb <= 1'b1;
      repeat (5) @(posedge i_clk);
      sck_tb <= 1'b0;
      repeat (5) @(posedge i_clk);
    end
    poll(ssp_pkg::OFS_ISTAT, ssp_pkg::IRQ_RX);
    rd_chk(ssp_pkg::OFS_BUF, 16'h00d2);
    chk(pk_rx & 16'h00ff, 16'h004b);
    wr(ssp_pkg::OFS_ISTAT, 16'h0007);
    wr(ssp_pkg::OFS_STAT, 16'h0000);
  endtask : t_slave

  initial begin
    i_arst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    pk_load = 1'b0;
    pk_w16 = 1'b0;
    pk_tx = 16'h0000;
    sck_tb = 1'b0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_pins();
    t_speed();
    t_over();
    t_frame();
    t_slave();
    finish_test();
  end
endmodule : tb
